/* pkg/sscr_pkg.sv */
// package: register map, field positions and reset values of the system control bank
package sscr_pkg;
  // =====================================================================
  // register offsets (page 1 for eah..efh, all pages for f0h..feh)
  localparam logic [7:0] ADDR_PLL_POWER   = 8'heb;
  localparam logic [7:0] ADDR_LANE_DRIVE  = 8'hec;
  localparam logic [7:0] ADDR_LANE_DELAY  = 8'hed;
  localparam logic [7:0] ADDR_LINK_PLL    = 8'hee;
  localparam logic [7:0] ADDR_LOOP_DIV    = 8'hef;
  localparam logic [7:0] ADDR_OP_MODE     = 8'hf0;
  localparam logic [7:0] ADDR_BYPASS      = 8'hf1;
  localparam logic [7:0] ADDR_SOFT_RESET  = 8'hf2;
  localparam logic [7:0] ADDR_STANDBY     = 8'hf3;
  localparam logic [7:0] ADDR_ORIENT      = 8'hf4;
  localparam logic [7:0] ADDR_REVISION    = 8'hfb;
  localparam logic [7:0] ADDR_PART_HIGH   = 8'hfc;
  localparam logic [7:0] ADDR_PART_LOW    = 8'hfd;
  localparam logic [7:0] ADDR_PAGE_SEL    = 8'hfe;
  localparam logic [7:0] ADDR_EXPOSURE_TRIGGER_PIN_CTRL   = 8'hea;
  localparam logic [7:0] ADDR_PAGED_LOW   = 8'hea;
  localparam logic [7:0] ADDR_COMMON_LOW  = 8'hf0;
  // =====================================================================
  // reset values
  localparam logic [7:0] RST_PLL_POWER    = 8'h0f;
  localparam logic [7:0] RST_LANE_DRIVE   = 8'h00;
  localparam logic [7:0] RST_LANE_DELAY   = 8'h00;
  localparam logic [7:0] RST_LINK_PLL     = 8'h66;
  localparam logic [7:0] RST_LOOP_DIV     = 8'h42;
  localparam logic [7:0] RST_OP_MODE      = 8'h01;
  localparam logic [7:0] RST_BYPASS       = 8'h00;
  localparam logic [7:0] RST_EXPOSURE_TRIGGER_PIN_CTRL    = 8'h35;
  localparam logic [1:0] RST_STANDBY      = 2'h0;
  localparam logic [1:0] RST_ORIENT       = 2'h0;
  localparam logic [1:0] RST_PAGE         = 2'h0;
  localparam logic [1:0] PAGE_0           = 2'h0;
  localparam logic [1:0] PAGE_1           = 2'h1;
  // =====================================================================
  // field positions
  localparam int OPM_PLL_ALWAYS   = 7;
  localparam int OPM_SYSCLK_RUN   = 6;
  localparam int OPM_CLK_GATE     = 5;
  localparam int OPM_VSYNC_DIS    = 4;
  localparam int OPM_CLK_SRC      = 3;
  localparam int OPM_MONO         = 0;
  localparam int PWR_LINK_PLL_OFF = 7;
  localparam int PWR_CONV_PLL_OFF = 6;
  localparam int BYP_CONTRAST     = 2;
  localparam int BYP_GAMMA        = 1;
  localparam int BYP_LENS         = 0;
  localparam int LPLL_PREDIV_HI   = 7;
  localparam int LPLL_PREDIV_LO   = 4;
  localparam int LPLL_POSTDIV     = 1;
  localparam int TRG_OUT_EN       = 4;
  localparam int TRG_CLK_FILTER   = 1;
  localparam int SBY_FRAME        = 1;
  localparam int SBY_PLAIN        = 0;
  localparam int ORI_MIRROR       = 1;
  localparam int ORI_FLIP         = 0;
  localparam int SRST_BIT         = 0;
  // =====================================================================
  // bus addresses and clock source codes
  localparam logic [6:0] SLAVE_ADDR_LOW   = 7'h6e;
  localparam logic [6:0] SLAVE_ADDR_HIGH  = 7'h6d;
  localparam logic [1:0] CLK_SRC_RAW      = 2'h0;
  localparam logic [1:0] CLK_SRC_LINK     = 2'h1;
  localparam logic [1:0] CLK_SRC_CONV     = 2'h2;
endpackage

/* hdl/sscr_regs.sv */
// system control register bank with serial configuration slave and strap pins
`timescale 1ns/10ps
// Behaviour
// - page field picks page zero or one
// - soft reset bit restores all registers
// - frame aligned standby enters at frame sync
// - plain standby enters immediately
// - mirror bit one, flip bit zero
// - mode bit seven keeps PLL always on
// - mode bit six keeps system clock running
// - mode bit five disables internal clock
// - mode bit four low enables frame sync
// - mode bit three picks clock source PLL
// - mode bit zero mono, default one
// - bypass bits active low enables
// - powered down PLL falls back raw clock
// - post divider bit halves link PLL
// - link PLL pre divider upper nibble
// - filter bit routes input clock deglitch
// - trigger output enable lets sensor drive
// - trigger input exposure, output illuminator pulse
// - powerdown pin low holds reset
// - address pin low 6eh, high 6dh
// - boot pin low slave, high eeprom
// - address increments after each data byte
// - writes outside map ignored, reads zero
module sscr_regs (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       CE_I,
  // serial bus (two-wire, sampled synchronously)
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  // straps and control pins
  input  wire logic       POWERDOWN_RESET_PIN_N_I,
  input  wire logic       SLAVE_ADDRESS_SEL_PIN_I,
  input  wire logic       BOOT_SOURCE_SEL_PIN_I,
  input  wire logic       FRAME_SYNC_I,
  input  wire logic       EXPOSURE_TRIGGER_PIN_I,
  output logic            EXPOSURE_TRIGGER_PIN_O,
  output logic            EXPOSURE_TRIGGER_PIN_OE_O,
  input  wire logic       INTEGRATION_PULSE_I,
  output logic            ILLUMINATOR_PULSE_PIN_O,
  output logic            TRIGGERED_EXPOSURE_O,
  // controls to the sensor core
  output logic            PLL_LINK_ON_O,
  output logic            PLL_CONV_ON_O,
  output logic [1:0]      SYSCLK_SRC_O,
  output logic            SYSCLK_RUN_O,
  output logic            CLK_GATE_O,
  output logic            VSYNC_OUT_EN_O,
  output logic            MONO_MODE_O,
  output logic            CONTRAST_EN_O,
  output logic            GAMMA_EN_O,
  output logic            LENS_EN_O,
  output logic [3:0]      LINK_PLL_PREDIV_O,
  output logic            LINK_PLL_HALVE_O,
  output logic            CLK_FILTER_EN_O,
  output logic            STANDBY_O,
  output logic            MIRROR_O,
  output logic            FLIP_O,
  output logic            EEPROM_BOOT_O
);
  import sscr_pkg::*;
  parameter logic [7:0] REVISION  = 8'h07; // arbitrary value
  parameter logic [7:0] PART_HIGH = 8'h5a; // arbitrary value
  parameter logic [7:0] PART_LOW  = 8'ha5; // arbitrary value

  typedef enum logic [2:0] {
    SSCR_IDLE = 3'b000, SSCR_DEVA = 3'b001, SSCR_REGA = 3'b010,
    SSCR_WDAT = 3'b011, SSCR_RDAT = 3'b100, SSCR_SKIP = 3'b101
  } sscr_state_e;

  // =====================================================================
  // bus line edge detection
  logic scl_q, sda_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (CE_I) begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
    end
  end
  wire scl_rise = SCL_I & ~scl_q;
  wire scl_fall = ~SCL_I & scl_q;
  wire start_c  = scl_q & SCL_I & sda_q & ~SDA_I;
  wire stop_c   = scl_q & SCL_I & ~sda_q & SDA_I;

  // =====================================================================
  // soft reset pulse and strap capture
  logic srst_q, strap_id_q, boot_q;
  wire  soft_clr = srst_q | ~POWERDOWN_RESET_PIN_N_I;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      strap_id_q <= 1'b0;
      boot_q     <= 1'b0;
    end else if (CE_I && !POWERDOWN_RESET_PIN_N_I) begin
      // straps are caught while held in reset, kept after release
      strap_id_q <= SLAVE_ADDRESS_SEL_PIN_I;
      boot_q     <= BOOT_SOURCE_SEL_PIN_I;
    end
  end
  wire [6:0] my_addr = strap_id_q ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW;

  // =====================================================================
  // serial slave state machine
  sscr_state_e st_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q, ptr_q, rd_q;
  logic        ack_q, rw_q, wr_stb_q;
  logic [7:0]  wr_addr_q, wr_data_q;
  logic [1:0]  page_q;

  function automatic logic in_page(input logic [7:0] a, input logic [1:0] pg);
    // common block always visible, paged block only on page one
    in_page = (a >= ADDR_COMMON_LOW) || (pg == PAGE_1 && a >= ADDR_PAGED_LOW);
  endfunction

  logic [7:0] rd_mux;
  logic [7:0] pll_pwr_q, drive_q, delay_q, lpll_q, loopdiv_q, mode_q, byp_q, trg_q;
  logic [1:0] sby_q, ori_q;
  always_comb begin
    rd_mux = 8'h00;
    if (in_page(ptr_q, page_q)) begin
      case (ptr_q)
        ADDR_EXPOSURE_TRIGGER_PIN_CTRL:  rd_mux = trg_q;
        ADDR_PLL_POWER:  rd_mux = pll_pwr_q;
        ADDR_LANE_DRIVE: rd_mux = drive_q;
        ADDR_LANE_DELAY: rd_mux = delay_q;
        ADDR_LINK_PLL:   rd_mux = lpll_q;
        ADDR_LOOP_DIV:   rd_mux = loopdiv_q;
        ADDR_OP_MODE:    rd_mux = mode_q;
        ADDR_BYPASS:     rd_mux = byp_q;
        ADDR_STANDBY:    rd_mux = {6'h00, sby_q};
        ADDR_ORIENT:     rd_mux = {6'h00, ori_q};
        ADDR_REVISION:   rd_mux = REVISION;
        ADDR_PART_HIGH:  rd_mux = PART_HIGH;
        ADDR_PART_LOW:   rd_mux = PART_LOW;
        ADDR_PAGE_SEL:   rd_mux = {6'h00, page_q};
        default:         rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q     <= SSCR_IDLE;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      ptr_q    <= 8'h00;
      rd_q     <= 8'h00;
      ack_q    <= 1'b0;
      rw_q     <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      SDA_O    <= 1'b0;
      SDA_OE_O <= 1'b0;
    end else if (CE_I) begin
      wr_stb_q <= 1'b0;
      if (soft_clr) begin
        // the serial interface is reset along with the registers
        st_q     <= SSCR_IDLE;
        SDA_OE_O <= 1'b0;
        ack_q    <= 1'b0;
      end else if (start_c) begin
        // repeated start keeps the pointer for a read after address write
        st_q     <= SSCR_DEVA;
        bit_q    <= 4'h0;
        ack_q    <= 1'b0;
        SDA_OE_O <= 1'b0;
      end else if (stop_c || boot_q) begin
        st_q     <= SSCR_IDLE;
        SDA_OE_O <= 1'b0;
      end else if (scl_rise && !ack_q && st_q != SSCR_IDLE) begin
        sh_q  <= {sh_q[6:0], SDA_I};
        bit_q <= bit_q + 4'h1;
      end else if (scl_rise && ack_q && st_q == SSCR_RDAT) begin
        // host answers no-acknowledge to end the read
        if (SDA_I) st_q <= SSCR_SKIP;
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_q    <= 1'b0;
          bit_q    <= 4'h0;
          SDA_OE_O <= (st_q == SSCR_RDAT) && !rd_q[7];
          SDA_O    <= 1'b0;
          if (!(st_q == SSCR_RDAT)) SDA_OE_O <= 1'b0;
        end else if (bit_q == 4'h8) begin
          ack_q    <= 1'b1;
          SDA_OE_O <= 1'b0;
          SDA_O    <= 1'b0;
          case (st_q)
            SSCR_DEVA: begin
              if (sh_q[7:1] == my_addr) begin
                SDA_OE_O <= 1'b1;
                rw_q     <= sh_q[0];
                st_q     <= sh_q[0] ? SSCR_RDAT : SSCR_REGA;
                rd_q     <= rd_mux;
              end else begin
                st_q  <= SSCR_SKIP;
                ack_q <= 1'b0;
              end
            end
            SSCR_REGA: begin
              SDA_OE_O <= 1'b1;
              ptr_q    <= sh_q;
              st_q     <= SSCR_WDAT;
            end
            SSCR_WDAT: begin
              SDA_OE_O  <= 1'b1;
              wr_stb_q  <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= sh_q;
              ptr_q     <= ptr_q + 8'h01;
            end
            SSCR_RDAT: begin
              ptr_q <= ptr_q + 8'h01;
            end
            default: begin
              ack_q <= 1'b0;
            end
          endcase
        end else if (st_q == SSCR_RDAT) begin
          // bit_q bits are already out, so the next one is bit 7 - bit_q
          SDA_O    <= 1'b0;
          SDA_OE_O <= !rd_q[3'(4'h7 - bit_q)];
        end
      end
      if (st_q == SSCR_RDAT && scl_fall && ack_q) begin
        rd_q     <= rd_mux;
        SDA_OE_O <= !rd_mux[7];
      end
    end
  end

  // =====================================================================
  // register file
  wire wr_hit = wr_stb_q && in_page(wr_addr_q, page_q);
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pll_pwr_q <= RST_PLL_POWER;
      drive_q   <= RST_LANE_DRIVE;
      delay_q   <= RST_LANE_DELAY;
      lpll_q    <= RST_LINK_PLL;
      loopdiv_q <= RST_LOOP_DIV;
      mode_q    <= RST_OP_MODE;
      byp_q     <= RST_BYPASS;
      trg_q     <= RST_EXPOSURE_TRIGGER_PIN_CTRL;
      sby_q     <= RST_STANDBY;
      ori_q     <= RST_ORIENT;
      page_q    <= RST_PAGE;
      srst_q    <= 1'b0;
    end else if (CE_I) begin
      srst_q <= 1'b0;
      if (soft_clr) begin
        pll_pwr_q <= RST_PLL_POWER;
        drive_q   <= RST_LANE_DRIVE;
        delay_q   <= RST_LANE_DELAY;
        lpll_q    <= RST_LINK_PLL;
        loopdiv_q <= RST_LOOP_DIV;
        mode_q    <= RST_OP_MODE;
        byp_q     <= RST_BYPASS;
        trg_q     <= RST_EXPOSURE_TRIGGER_PIN_CTRL;
        sby_q     <= RST_STANDBY;
        ori_q     <= RST_ORIENT;
        page_q    <= RST_PAGE;
      end else if (wr_hit) begin
        case (wr_addr_q)
          ADDR_EXPOSURE_TRIGGER_PIN_CTRL:  trg_q     <= wr_data_q;
          ADDR_PLL_POWER:  pll_pwr_q <= wr_data_q;
          ADDR_LANE_DRIVE: drive_q   <= wr_data_q;
          ADDR_LANE_DELAY: delay_q   <= wr_data_q;
          ADDR_LINK_PLL:   lpll_q    <= wr_data_q;
          ADDR_LOOP_DIV:   loopdiv_q <= wr_data_q;
          ADDR_OP_MODE:    mode_q    <= wr_data_q;
          ADDR_BYPASS:     byp_q     <= wr_data_q;
          ADDR_SOFT_RESET: srst_q    <= wr_data_q[SRST_BIT];
          ADDR_STANDBY:    sby_q     <= wr_data_q[1:0];
          ADDR_ORIENT:     ori_q     <= wr_data_q[1:0];
          ADDR_PAGE_SEL:   page_q    <= wr_data_q[1:0];
          default:         ;
        endcase
      end
    end
  end

  // =====================================================================
  // standby: frame aligned request waits for the frame sync edge
  logic fs_q, sby_frame_q;
  wire  fs_rise = FRAME_SYNC_I & ~fs_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fs_q        <= 1'b0;
      sby_frame_q <= 1'b0;
    end else if (CE_I) begin
      fs_q <= FRAME_SYNC_I;
      if (soft_clr) sby_frame_q <= 1'b0;
      else if (fs_rise) sby_frame_q <= sby_q[SBY_FRAME];
    end
  end
  wire standby_now = sby_q[SBY_PLAIN] | sby_frame_q;

  // =====================================================================
  // registered outputs to the core
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PLL_LINK_ON_O <= 1'b0;
      PLL_CONV_ON_O <= 1'b0;
      SYSCLK_SRC_O  <= CLK_SRC_RAW;
      SYSCLK_RUN_O  <= 1'b0;
      CLK_GATE_O    <= 1'b0;
      VSYNC_OUT_EN_O <= 1'b0;
      MONO_MODE_O   <= 1'b1;
      CONTRAST_EN_O <= 1'b0;
      GAMMA_EN_O    <= 1'b0;
      LENS_EN_O     <= 1'b0;
      LINK_PLL_PREDIV_O <= 4'h0;
      LINK_PLL_HALVE_O  <= 1'b0;
      CLK_FILTER_EN_O   <= 1'b0;
      STANDBY_O     <= 1'b0;
      MIRROR_O      <= 1'b0;
      FLIP_O        <= 1'b0;
      EEPROM_BOOT_O <= 1'b0;
      EXPOSURE_TRIGGER_PIN_O    <= 1'b0;
      EXPOSURE_TRIGGER_PIN_OE_O <= 1'b0;
      ILLUMINATOR_PULSE_PIN_O   <= 1'b0;
      TRIGGERED_EXPOSURE_O      <= 1'b0;
    end else if (CE_I) begin
      PLL_LINK_ON_O <= mode_q[OPM_PLL_ALWAYS] | ~pll_pwr_q[PWR_LINK_PLL_OFF];
      PLL_CONV_ON_O <= mode_q[OPM_PLL_ALWAYS] | ~pll_pwr_q[PWR_CONV_PLL_OFF];
      if (mode_q[OPM_CLK_SRC])
        SYSCLK_SRC_O <= (pll_pwr_q[PWR_CONV_PLL_OFF] && !mode_q[OPM_PLL_ALWAYS]) ? CLK_SRC_RAW : CLK_SRC_CONV;
      else
        SYSCLK_SRC_O <= (pll_pwr_q[PWR_LINK_PLL_OFF] && !mode_q[OPM_PLL_ALWAYS]) ? CLK_SRC_RAW : CLK_SRC_LINK;
      SYSCLK_RUN_O  <= mode_q[OPM_SYSCLK_RUN] | ~standby_now;
      CLK_GATE_O    <= mode_q[OPM_CLK_GATE];
      VSYNC_OUT_EN_O <= ~mode_q[OPM_VSYNC_DIS];
      MONO_MODE_O   <= mode_q[OPM_MONO];
      CONTRAST_EN_O <= ~byp_q[BYP_CONTRAST];
      GAMMA_EN_O    <= ~byp_q[BYP_GAMMA];
      LENS_EN_O     <= ~byp_q[BYP_LENS];
      LINK_PLL_PREDIV_O <= lpll_q[LPLL_PREDIV_HI:LPLL_PREDIV_LO];
      LINK_PLL_HALVE_O  <= lpll_q[LPLL_POSTDIV];
      CLK_FILTER_EN_O   <= trg_q[TRG_CLK_FILTER];
      STANDBY_O     <= standby_now | ~POWERDOWN_RESET_PIN_N_I;
      MIRROR_O      <= ori_q[ORI_MIRROR];
      FLIP_O        <= ori_q[ORI_FLIP];
      EEPROM_BOOT_O <= boot_q;
      EXPOSURE_TRIGGER_PIN_OE_O <= trg_q[TRG_OUT_EN];
      EXPOSURE_TRIGGER_PIN_O    <= trg_q[TRG_OUT_EN] & INTEGRATION_PULSE_I;
      ILLUMINATOR_PULSE_PIN_O   <= INTEGRATION_PULSE_I;
      TRIGGERED_EXPOSURE_O      <= ~trg_q[TRG_OUT_EN] & EXPOSURE_TRIGGER_PIN_I;
    end
  end

  // =====================================================================
  // checks
  sequence s_frame_req;
    CE_I && sby_q[SBY_FRAME] && !sby_q[SBY_PLAIN] && !fs_rise && !sby_frame_q && !soft_clr;
  endsequence
  a_page_select_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && wr_hit && wr_addr_q == ADDR_PAGE_SEL && !soft_clr |=> page_q == $past(wr_data_q[1:0]))
    else $error("page select not updated");
  a_soft_reset_mode: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && srst_q |=> mode_q == RST_OP_MODE && page_q == RST_PAGE)
    else $error("soft reset did not restore registers");
  a_frame_standby_wait: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_frame_req |=> !sby_frame_q)
    else $error("frame standby entered off boundary");
  a_plain_standby: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && sby_q[SBY_PLAIN] |=> !CE_I || STANDBY_O)
    else $error("plain standby not taken");
  a_orient_out: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I |=> !CE_I || (MIRROR_O == $past(ori_q[ORI_MIRROR]) && FLIP_O == $past(ori_q[ORI_FLIP])))
    else $error("orientation output wrong");
  a_vsync_sense: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I |=> !CE_I || VSYNC_OUT_EN_O != $past(mode_q[OPM_VSYNC_DIS]))
    else $error("vsync enable sense wrong");
  a_bypass_sense: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I |=> !CE_I || (LENS_EN_O != $past(byp_q[BYP_LENS]) && GAMMA_EN_O != $past(byp_q[BYP_GAMMA])))
    else $error("bypass enable sense wrong");
  a_raw_fallback: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && !mode_q[OPM_PLL_ALWAYS] && !mode_q[OPM_CLK_SRC] && pll_pwr_q[PWR_LINK_PLL_OFF]
    |=> !CE_I || SYSCLK_SRC_O == CLK_SRC_RAW)
    else $error("no raw clock fallback");
  a_addr_incr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && wr_stb_q |-> ptr_q == wr_addr_q + 8'h01)
    else $error("address not incremented");
endmodule

/* bench/sscr_host_model.sv */
// host controller model on the two-wire configuration bus
`timescale 1ns/10ps
module sscr_host_model (
  // clock
  input  wire logic CLK_I,
  // bus lines, data is open drain with a pull-up on the wire
  output logic      SCL_O,
  output logic      SDA_PULL_O,
  input  wire logic SDA_I
);
  // half period above the minimum of 4 system clocks
  localparam int HALF = 6;
  initial begin
    SCL_O = 1'b1;
    SDA_PULL_O = 1'b0;
  end
  // =====================================================================
  // bit level
  task automatic tick();
    repeat (HALF) @(negedge CLK_I);
  endtask
  task automatic start();
    SDA_PULL_O = 1'b0;
    tick();
    SCL_O = 1'b1;
    tick();
    SDA_PULL_O = 1'b1;
    tick();
    SCL_O = 1'b0;
  endtask
  task automatic stop();
    SDA_PULL_O = 1'b1;
    tick();
    SCL_O = 1'b1;
    tick();
    SDA_PULL_O = 1'b0;
    tick();
  endtask
  // data moves two clocks after the falling edge, never with it
  task automatic clk_bit(input logic b, output logic got);
    repeat (2) @(negedge CLK_I);
    SDA_PULL_O = !b;
    tick();
    SCL_O = 1'b1;
    tick();
    got = SDA_I;
    SCL_O = 1'b0;
  endtask
  // =====================================================================
  // byte level
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], g);
    clk_bit(1'b1, g);
    ack = !g;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(last, g);
  endtask
  // =====================================================================
  // transfers
  task automatic write_burst(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d[$], output logic ok);
    logic g;
    start();
    send_byte({dev, 1'b0}, ok);
    if (ok) begin
      send_byte(a, g);
      foreach (d[i]) send_byte(d[i], g);
    end
    stop();
  endtask
  task automatic read_burst(input logic [6:0] dev, input logic [7:0] a, input int n, output logic [7:0] d[$],
                            output logic ok);
    logic       g;
    logic [7:0] b;
    d = {};
    start();
    send_byte({dev, 1'b0}, ok);
    if (ok) begin
      send_byte(a, g);
      start();
      send_byte({dev, 1'b1}, g);
      for (int i = 0; i < n; i++) begin
        recv_byte(i == n - 1, b);
        d.push_back(b);
      end
    end
    stop();
  endtask
endmodule

/* bench/tb.sv */
// self-checking bench of the system control register bank
`timescale 1ns/10ps
module tb;
  import sscr_pkg::*;
  // =====================================================================
  // clock, pins and wires
  logic       clk = 1'b0;
  logic       ce = 1'b1;
  logic       rst_n = 1'b0;
  logic       pd_n = 1'b0;
  logic       addr_sel = 1'b0;
  logic       boot_sel = 1'b0;
  logic       fsync = 1'b0;
  logic       exposure_trigger_pin_in = 1'b0;
  logic       integ = 1'b0;
  logic [6:0] dev = SLAVE_ADDR_LOW;
  logic       scl, host_pull, SDA_O, SDA_OE_O, EXPOSURE_TRIGGER_PIN_O, EXPOSURE_TRIGGER_PIN_OE_O;
  logic       ILLUMINATOR_PULSE_PIN_O, TRIGGERED_EXPOSURE_O, PLL_LINK_ON_O, PLL_CONV_ON_O, SYSCLK_RUN_O;
  logic       CLK_GATE_O, VSYNC_OUT_EN_O, MONO_MODE_O, CONTRAST_EN_O, GAMMA_EN_O, LENS_EN_O, LINK_PLL_HALVE_O;
  logic       CLK_FILTER_EN_O, STANDBY_O, MIRROR_O, FLIP_O, EEPROM_BOOT_O;
  logic [1:0] SYSCLK_SRC_O;
  logic [3:0] LINK_PLL_PREDIV_O;
  int         failures = 0;
  int         n_compared = 0;
  wire        sda = !(host_pull || (SDA_OE_O && !SDA_O));
  always #20 clk = ~clk;
  sscr_regs i_sscr_regs (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SCL_I(scl), .SDA_I(sda), .SDA_O, .SDA_OE_O,
    .POWERDOWN_RESET_PIN_N_I(pd_n), .SLAVE_ADDRESS_SEL_PIN_I(addr_sel), .BOOT_SOURCE_SEL_PIN_I(boot_sel),
    .FRAME_SYNC_I(fsync), .EXPOSURE_TRIGGER_PIN_I(exposure_trigger_pin_in), .EXPOSURE_TRIGGER_PIN_O, .EXPOSURE_TRIGGER_PIN_OE_O,
    .INTEGRATION_PULSE_I(integ), .ILLUMINATOR_PULSE_PIN_O, .TRIGGERED_EXPOSURE_O, .PLL_LINK_ON_O, .PLL_CONV_ON_O,
    .SYSCLK_SRC_O, .SYSCLK_RUN_O, .CLK_GATE_O, .VSYNC_OUT_EN_O, .MONO_MODE_O, .CONTRAST_EN_O, .GAMMA_EN_O,
    .LENS_EN_O, .LINK_PLL_PREDIV_O, .LINK_PLL_HALVE_O, .CLK_FILTER_EN_O, .STANDBY_O, .MIRROR_O, .FLIP_O,
    .EEPROM_BOOT_O);
  sscr_host_model i_sscr_host_model (.CLK_I(clk), .SCL_O(scl), .SDA_PULL_O(host_pull), .SDA_I(sda));
  // =====================================================================
  // helpers
  task automatic test_done();
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_sscr_host_model.write_burst(dev, a, '{d}, ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q[$];
    logic       ok;
    i_sscr_host_model.read_burst(dev, a, 1, q, ok);
    chk(q[0], exp);
  endtask
  task automatic pd_cycle(input logic sel, input logic boot);
    pd_n = 1'b0;
    addr_sel = sel;
    boot_sel = boot;
    repeat (3) @(negedge clk);
    chk({MIRROR_O, FLIP_O, 6'h0}, 8'h00);
    pd_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  // =====================================================================
  // scenarios
  task automatic t_defaults();
    logic [7:0] q[$];
    logic [7:0] e[5] = '{RST_OP_MODE, RST_BYPASS, 8'h00, 8'h00, 8'h00};
    logic       ok;
    chk({PLL_LINK_ON_O, PLL_CONV_ON_O, MONO_MODE_O, CONTRAST_EN_O, GAMMA_EN_O, LENS_EN_O, VSYNC_OUT_EN_O,
         CLK_GATE_O}, 8'hfe);
    chk({SYSCLK_SRC_O, EXPOSURE_TRIGGER_PIN_OE_O, EEPROM_BOOT_O, STANDBY_O, 3'h0}, 8'h60);
    i_sscr_host_model.read_burst(dev, ADDR_OP_MODE, 5, q, ok);
    foreach (e[i]) chk(q[i], e[i]);
  endtask
  task automatic t_mode();
    logic ok;
    wr(ADDR_OP_MODE, 8'h78);
    chk({SYSCLK_RUN_O, CLK_GATE_O, VSYNC_OUT_EN_O, MONO_MODE_O, SYSCLK_SRC_O, 2'h0}, 8'hc8);
    i_sscr_host_model.write_burst(dev, ADDR_OP_MODE, '{8'h00, 8'h07}, ok);
    chk({SYSCLK_SRC_O, VSYNC_OUT_EN_O, MONO_MODE_O, CONTRAST_EN_O, GAMMA_EN_O, LENS_EN_O, SYSCLK_RUN_O},
        8'h61);
  endtask
  task automatic t_pll_page();
    wr(ADDR_PAGE_SEL, {6'h0, PAGE_1});
    wr(ADDR_PLL_POWER, 8'h80);
    chk({PLL_LINK_ON_O, PLL_CONV_ON_O, SYSCLK_SRC_O, 4'h0}, 8'h40);
    wr(ADDR_OP_MODE, 8'h80);
    chk({PLL_LINK_ON_O, 7'h0}, 8'h80);
    wr(ADDR_LINK_PLL, 8'h92);
    chk({LINK_PLL_PREDIV_O, LINK_PLL_HALVE_O, 3'h0}, 8'h98);
    wr(ADDR_EXPOSURE_TRIGGER_PIN_CTRL, 8'h02);
    exposure_trigger_pin_in = 1'b1;
    repeat (3) @(negedge clk);
    chk({CLK_FILTER_EN_O, EXPOSURE_TRIGGER_PIN_OE_O, TRIGGERED_EXPOSURE_O, 5'h0}, 8'ha0);
    exposure_trigger_pin_in = 1'b0;
    wr(ADDR_EXPOSURE_TRIGGER_PIN_CTRL, 8'h12);
    ce = 1'b0;
    integ = 1'b1;
    repeat (3) @(negedge clk);
    chk({ILLUMINATOR_PULSE_PIN_O, 7'h0}, 8'h00);
    ce = 1'b1;
    repeat (3) @(negedge clk);
    chk({EXPOSURE_TRIGGER_PIN_O, ILLUMINATOR_PULSE_PIN_O, EXPOSURE_TRIGGER_PIN_OE_O, 5'h0}, 8'he0);
    integ = 1'b0;
    rd(ADDR_PAGE_SEL, {6'h0, PAGE_1});
    wr(ADDR_PAGE_SEL, {6'h0, PAGE_0});
    wr(ADDR_LINK_PLL, 8'h33);
    chk({LINK_PLL_PREDIV_O, 4'h0}, 8'h90);
    rd(ADDR_LINK_PLL, 8'h00);
    rd(ADDR_PAGE_SEL, {6'h0, PAGE_0});
  endtask
  task automatic t_standby_orient();
    int i;
    wr(ADDR_STANDBY, 8'h01);
    chk({STANDBY_O, SYSCLK_RUN_O, 6'h0}, 8'h80);
    wr(ADDR_STANDBY, 8'h00);
    chk({STANDBY_O, 7'h0}, 8'h00);
    wr(ADDR_STANDBY, 8'h02);
    chk({STANDBY_O, 7'h0}, 8'h00);
    fsync = 1'b1;
    for (i = 0; i < 8 && STANDBY_O !== 1'b1; i++) @(negedge clk);
    chk({STANDBY_O, 7'h0}, 8'h80);
    fsync = 1'b0;
    wr(ADDR_ORIENT, 8'h02);
    chk({MIRROR_O, FLIP_O, 6'h0}, 8'h80);
    wr(ADDR_ORIENT, 8'h01);
    chk({MIRROR_O, FLIP_O, 6'h0}, 8'h40);
  endtask
  task automatic t_reset_range();
    logic ok;
    wr(ADDR_SOFT_RESET, 8'h01);
    chk({MIRROR_O, FLIP_O, STANDBY_O, MONO_MODE_O, CONTRAST_EN_O, GAMMA_EN_O, LENS_EN_O, CLK_GATE_O}, 8'h1e);
    chk({LINK_PLL_PREDIV_O, PLL_LINK_ON_O, 3'h0}, 8'h68);
    rd(ADDR_OP_MODE, RST_OP_MODE);
    i_sscr_host_model.write_burst(dev, ADDR_ORIENT, '{8'h03, 8'haa, 8'h55}, ok);
    chk({MIRROR_O, FLIP_O, 6'h0}, 8'hc0);
    rd(8'hf5, 8'h00);
  endtask
  task automatic t_straps();
    logic ok;
    wr(ADDR_ORIENT, 8'h02);
    pd_cycle(1'b1, 1'b0);
    i_sscr_host_model.write_burst(SLAVE_ADDR_LOW, ADDR_ORIENT, '{8'h01}, ok);
    chk({ok, FLIP_O, 6'h0}, 8'h00);
    i_sscr_host_model.write_burst(SLAVE_ADDR_HIGH, ADDR_ORIENT, '{8'h01}, ok);
    chk({ok, FLIP_O, 6'h0}, 8'hc0);
    pd_cycle(1'b0, 1'b1);
    i_sscr_host_model.write_burst(SLAVE_ADDR_LOW, ADDR_ORIENT, '{8'h01}, ok);
    chk({ok, FLIP_O, EEPROM_BOOT_O, 5'h0}, 8'h20);
  endtask
  // =====================================================================
  // main sequence and hang guard
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    pd_n = 1'b1;
    repeat (3) @(negedge clk);
    t_defaults();
    t_mode();
    t_pll_page();
    t_standby_orient();
    t_reset_range();
    t_straps();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule
